// File: core/reset_mode_select_watchdog_stop.sv
// Reset-time mode selection, liveness watchdog and stop/wait handling
//
// Functional notes
// - Every reset, including a watchdog reset, leaves the watchdog enabled.
// - Writing zero to option bit 6 disables the watchdog.
// - With the watchdog enabled a stop request is executed as wait.
// - A watchdog timeout resets the device, also during wait.
// - Normal interrupt level at reset release selects user mode.
// - Elevated interrupt level plus mode pin high selects self-check mode.
// - Mode pin is latched within two cycles of reset release, then freed.
// - Self-check branches to the test program at 1600-17FF and repeats.
// - Passing self-check toggles the four report LEDs.
// - A failure holds a steady four-bit fault code on the LEDs.
//
// The Wishbone register port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "rms_defs.svh"

module reset_mode_select_watchdog_stop #(
  parameter int unsigned WDOG_TIMEOUT_CYC = `RMS_WDOG_TIMEOUT_CYC,
  parameter logic [15:0] USER_VECTOR = 16'h0000
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Pins from the board or fixture
  input wire logic irq_n_i,
  input wire logic irq_hv_i,
  input wire logic mode_select_pin_i,
  // Clock and reset control toward the core
  output logic cpu_clk_en_o,
  output logic osc_en_o,
  output logic wdog_reset_o,
  // Mode and program start
  output logic self_check_mode_o,
  output logic [15:0] boot_vector_o,
  output logic selftest_restart_o,
  // Report LEDs
  output logic report_led_3_o,
  output logic report_led_2_o,
  output logic report_led_1_o,
  output logic report_led_0_o
);

  // Pin synchronisers: index 0 irq_n, 1 irq_hv, 2 mode pin
  logic [2:0] pin_meta_ff;
  logic [2:0] pin_sync_ff;
  logic [2:0] pin_raw;

  logic int_rst;
  logic [1:0] wdog_rst_cnt_ff;
  logic wdog_reset_ff;
  logic wdog_timeout;

  logic [1:0] rel_cnt_ff;
  logic mode_latched_ff;
  logic self_check_ff;
  logic [15:0] boot_vector_ff;
  logic restart_ff;

  logic [7:0] option_ff;
  logic wdog_en;

  rms_pkg::lp_state_e lp_ff;
  rms_pkg::lp_state_e nxt_lp;
  logic [11:0] recover_cnt_ff;
  logic cpu_clk_en_ff;
  logic osc_en_ff;

  logic ack_ff;
  logic [31:0] dat_ff;
  logic bus_req;
  logic wr_done;
  logic [5:0] reg_idx;
  logic cmd_wait;
  logic cmd_stop;
  logic cmd_service;
  logic res_pass;
  logic res_fail;
  logic wake;
  logic [3:0] led;
  logic failed;
  logic [3:0] led_ff;

  assign pin_raw = {mode_select_pin_i, irq_hv_i, irq_n_i};

  // Two flops per pin; only the second stage is read by logic
  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_pin_sync
      always_ff @(posedge clk_i)
      begin
        pin_meta_ff[g] <= pin_raw[g];
        pin_sync_ff[g] <= pin_meta_ff[g];
      end
    end
  endgenerate

  // Internal reset covers the pin reset and the watchdog reset pulse
  assign int_rst = rst_i | wdog_reset_ff;

  // Watchdog reset pulse: at least 1.5 cycles wide, so two cycles
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wdog_rst_cnt_ff <= 2'h0;
      wdog_reset_ff <= 1'b0;
    end
    else if (wdog_timeout)
    begin
      wdog_rst_cnt_ff <= `RMS_WDOG_RST_CYC - 2'h1;
      wdog_reset_ff <= 1'b1;
    end
    else if (wdog_rst_cnt_ff != 2'h0)
    begin
      wdog_rst_cnt_ff <= wdog_rst_cnt_ff - 2'h1;
      wdog_reset_ff <= 1'b1;
    end
    else
    begin
      wdog_reset_ff <= 1'b0;
    end
  end

  // Cycles since reset release; the mode is sampled once inside the window
  always_ff @(posedge clk_i)
  begin
    if (int_rst)
      rel_cnt_ff <= 2'h0;
    else if (rel_cnt_ff != `RMS_MODE_HOLD_CYC)
      rel_cnt_ff <= rel_cnt_ff + 2'h1;
  end

  // Mode latch; after it the mode pin and irq pin go back to normal use
  always_ff @(posedge clk_i)
  begin
    if (int_rst)
    begin
      mode_latched_ff <= 1'b0;
      self_check_ff <= 1'b0;
      boot_vector_ff <= USER_VECTOR;
    end
    else if (!mode_latched_ff && rel_cnt_ff == `RMS_MODE_LATCH_CYC)
    begin
      mode_latched_ff <= 1'b1;
      // Elevated irq level alone is not enough: the mode pin must be high too
      self_check_ff <= pin_sync_ff[1] & pin_sync_ff[2];
      boot_vector_ff <= (pin_sync_ff[1] & pin_sync_ff[2]) ? `RMS_SELFTEST_BASE
                                                          : USER_VECTOR;
    end
  end

  // Option register; the watchdog enable can only be cleared until reset
  always_ff @(posedge clk_i)
  begin
    if (int_rst)
      option_ff <= `RMS_OPTION_RESET;
    else if (wr_done && reg_idx == `RMS_IDX_OPTION)
    begin
      option_ff <= wb_dat_i[7:0];
      option_ff[`RMS_OPT_WDOG_BIT] <= option_ff[`RMS_OPT_WDOG_BIT]
                                      & wb_dat_i[`RMS_OPT_WDOG_BIT];
    end
  end

  assign wdog_en = option_ff[`RMS_OPT_WDOG_BIT];

  // Wishbone decode
  assign bus_req = wb_cyc_i & wb_stb_i;
  assign wr_done = bus_req & wb_we_i & ack_ff & wb_sel_i[0];
  assign reg_idx = wb_adr_i[7:2];
  assign cmd_wait = wr_done && reg_idx == `RMS_IDX_CMD && wb_dat_i[`RMS_CMD_WAIT_BIT];
  assign cmd_stop = wr_done && reg_idx == `RMS_IDX_CMD && wb_dat_i[`RMS_CMD_STOP_BIT];
  assign cmd_service = wr_done && reg_idx == `RMS_IDX_CMD
                       && wb_dat_i[`RMS_CMD_SERVICE_BIT];
  assign res_pass = wr_done && reg_idx == `RMS_IDX_RESULT
                    && wb_dat_i[`RMS_RES_PASS_BIT];
  assign res_fail = wr_done && reg_idx == `RMS_IDX_RESULT
                    && wb_dat_i[`RMS_RES_FAIL_BIT];

  // Ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_ff <= 1'b0;
    else
      ack_ff <= bus_req & ~ack_ff;
  end

  // Read data captured with the ack; unmapped and write-only reads give zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dat_ff <= 32'h00000000;
    else if (bus_req && !ack_ff && !wb_we_i)
    begin
      if (reg_idx == `RMS_IDX_OPTION)
        dat_ff <= {24'h000000, option_ff};
      else if (reg_idx == `RMS_IDX_STATUS)
      begin
        dat_ff <= 32'h00000000;
        dat_ff[`RMS_ST_SELFCHK_BIT] <= self_check_ff;
        dat_ff[`RMS_ST_LATCHED_BIT] <= mode_latched_ff;
        dat_ff[`RMS_ST_WDOG_BIT] <= wdog_en;
        dat_ff[`RMS_ST_LP_LSB +: 4] <= lp_ff;
        dat_ff[`RMS_ST_LED_LSB +: 4] <= led_ff;
        dat_ff[`RMS_ST_FAILED_BIT] <= failed;
      end
      else
        dat_ff <= 32'h00000000;
    end
  end

  // An asserted, non-masked interrupt wakes the core
  assign wake = ~pin_sync_ff[0];

  // Low-power state machine; commands are only heard while running
  always_comb
  begin
    nxt_lp = lp_ff;
    case (lp_ff)
      rms_pkg::LP_RUN:
      begin
        if (cmd_stop && !wdog_en)
          nxt_lp = rms_pkg::LP_STOP;
        else if (cmd_stop || cmd_wait)
          nxt_lp = rms_pkg::LP_WAIT;
      end
      rms_pkg::LP_WAIT:
        if (wake)
          nxt_lp = rms_pkg::LP_RUN;
      rms_pkg::LP_STOP:
        if (wake)
          nxt_lp = rms_pkg::LP_RECOVER;
      rms_pkg::LP_RECOVER:
        if (recover_cnt_ff == 12'h000)
          nxt_lp = rms_pkg::LP_RUN;
      default: nxt_lp = rms_pkg::LP_RUN;
    endcase
  end

  // State, oscillator restart delay and clock gates toward the core
  always_ff @(posedge clk_i)
  begin
    if (int_rst)
    begin
      lp_ff <= rms_pkg::LP_RUN;
      recover_cnt_ff <= 12'h000;
      cpu_clk_en_ff <= 1'b1;
      osc_en_ff <= 1'b1;
    end
    else
    begin
      lp_ff <= nxt_lp;
      if (nxt_lp == rms_pkg::LP_RECOVER && lp_ff == rms_pkg::LP_STOP)
        recover_cnt_ff <= `RMS_STOP_RECOVER_CYC - 12'h001;
      else if (recover_cnt_ff != 12'h000)
        recover_cnt_ff <= recover_cnt_ff - 12'h001;
      cpu_clk_en_ff <= (nxt_lp == rms_pkg::LP_RUN);
      osc_en_ff <= (nxt_lp != rms_pkg::LP_STOP);
    end
  end

  // Watchdog keeps counting in wait; it cannot meet stop while enabled
  liveness_watchdog #(
    .TIMEOUT_CYC(WDOG_TIMEOUT_CYC)
  ) u_watchdog (
    .clk_i(clk_i),
    .rst_i(int_rst),
    .run_i(wdog_en && lp_ff != rms_pkg::LP_STOP),
    .service_i(cmd_service),
    .timeout_o(wdog_timeout)
  );

  // Self-test restart: a pass sends the core back to the program start
  always_ff @(posedge clk_i)
  begin
    if (int_rst)
      restart_ff <= 1'b0;
    else
      restart_ff <= self_check_ff & res_pass & ~failed;
  end

  self_check_reporter u_reporter (
    .clk_i(clk_i),
    .rst_i(int_rst),
    .active_i(self_check_ff),
    .pass_i(res_pass),
    .fail_i(res_fail),
    .unit_i(wb_dat_i[`RMS_RES_UNIT_MSB:0]),
    .led_o(led),
    .failed_o(failed)
  );

  // LED copy kept as a flop here so the pins come straight from registers
  always_ff @(posedge clk_i)
  begin
    if (int_rst)
      led_ff <= `RMS_LED_IDLE;
    else
      led_ff <= led;
  end

  // Outputs
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;
  assign cpu_clk_en_o = cpu_clk_en_ff;
  assign osc_en_o = osc_en_ff;
  assign wdog_reset_o = wdog_reset_ff;
  assign self_check_mode_o = self_check_ff;
  assign boot_vector_o = boot_vector_ff;
  assign selftest_restart_o = restart_ff;
  assign report_led_3_o = led_ff[3];
  assign report_led_2_o = led_ff[2];
  assign report_led_1_o = led_ff[1];
  assign report_led_0_o = led_ff[0];

endmodule : reset_mode_select_watchdog_stop

`default_nettype wire

// File: core/rms_defs.svh
// Offsets, field positions, reset values and cycle counts of the reset/mode/watchdog block
`ifndef RMS_DEFS_SVH
`define RMS_DEFS_SVH

// Register indices; byte address is four times the index
`define RMS_IDX_OPTION 6'h1D
`define RMS_IDX_CMD 6'h20
`define RMS_IDX_STATUS 6'h21
`define RMS_IDX_RESULT 6'h22

// Option configuration register
`define RMS_OPTION_RESET 8'h40
`define RMS_OPT_WDOG_BIT 6

// Command register bits (write only)
`define RMS_CMD_WAIT_BIT 0
`define RMS_CMD_STOP_BIT 1
`define RMS_CMD_SERVICE_BIT 2

// Self-test result register bits (write only)
`define RMS_RES_PASS_BIT 7
`define RMS_RES_FAIL_BIT 6
`define RMS_RES_UNIT_MSB 3

// Status register field positions
`define RMS_ST_SELFCHK_BIT 0
`define RMS_ST_LATCHED_BIT 1
`define RMS_ST_WDOG_BIT 2
`define RMS_ST_LP_LSB 4
`define RMS_ST_LED_LSB 8
`define RMS_ST_FAILED_BIT 12

// Self-test program location
`define RMS_SELFTEST_BASE 16'h1600
`define RMS_SELFTEST_END 16'h17FF

// Timing, in processor clock cycles
`define RMS_WDOG_TIMEOUT_CYC 114688
`define RMS_WDOG_RST_CYC 2'h2
`define RMS_STOP_RECOVER_CYC 12'hFE0
`define RMS_MODE_LATCH_CYC 2'h1
`define RMS_MODE_HOLD_CYC 2'h2

// Report LED codes, 1 = LED off
`define RMS_LED_IDLE 4'hF
`define RMS_LED_PORTA 4'hF
`define RMS_LED_PORTB 4'hE
`define RMS_LED_PORTC 4'hD
`define RMS_LED_RAM 4'hC
`define RMS_LED_ROM 4'hB
`define RMS_LED_IRQ 4'hA
`define RMS_LED_KEYPRESS 4'h9
`define RMS_LED_TIMER 4'h7
`define RMS_LED_PWM 4'h6

`endif

// File: core/rms_pkg.sv
// Types shared by the reset/mode/watchdog block
package rms_pkg;

  // Low-power state, one-hot
  typedef enum logic [3:0] {
    LP_RUN = 4'h1,
    LP_WAIT = 4'h2,
    LP_STOP = 4'h4,
    LP_RECOVER = 4'h8
  } lp_state_e;

  // Unit identifiers reported by the self-test program
  typedef enum logic [3:0] {
    UNIT_PORTA = 4'h0,
    UNIT_PORTB = 4'h1,
    UNIT_PORTC = 4'h2,
    UNIT_RAM = 4'h3,
    UNIT_ROM = 4'h4,
    UNIT_IRQ = 4'h5,
    UNIT_KEYPRESS = 4'h6,
    UNIT_TIMER = 4'h7,
    UNIT_PWM = 4'h8
  } unit_e;

endpackage : rms_pkg

// File: core/liveness_watchdog.sv
// Liveness watchdog counter with service and timeout pulse
`timescale 1ns/100ps
`default_nettype none

module liveness_watchdog #(
  parameter int unsigned TIMEOUT_CYC = 114688
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic run_i,
  input wire logic service_i,
  // Event
  output logic timeout_o
);

  logic [16:0] count_ff;
  logic timeout_ff;

  // Count while running; service or timeout restarts the period
  always_ff @(posedge clk_i)
  begin
    if (rst_i || service_i || !run_i)
    begin
      count_ff <= 17'h00000;
      timeout_ff <= 1'b0;
    end
    else if (count_ff == 17'(TIMEOUT_CYC - 1))
    begin
      count_ff <= 17'h00000;
      timeout_ff <= 1'b1;
    end
    else
    begin
      count_ff <= count_ff + 17'h00001;
      timeout_ff <= 1'b0;
    end
  end

  assign timeout_o = timeout_ff;

endmodule : liveness_watchdog

`default_nettype wire

// File: core/self_check_reporter.sv
// Self-check LED reporter: flashes on pass, holds a fault code on fail
`timescale 1ns/100ps
`default_nettype none
`include "rms_defs.svh"

module self_check_reporter (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Result events from the test program
  input wire logic active_i,
  input wire logic pass_i,
  input wire logic fail_i,
  input wire logic [3:0] unit_i,
  // Report
  output logic [3:0] led_o,
  output logic failed_o
);

  logic [3:0] led_ff;
  logic failed_ff;
  logic [3:0] fault_code;
  logic code_ok;

  // Unit to LED pattern; unknown units leave the report alone
  always_comb
  begin
    fault_code = `RMS_LED_IDLE;
    code_ok = 1'b1;
    case (unit_i)
      rms_pkg::UNIT_PORTA: fault_code = `RMS_LED_PORTA;
      rms_pkg::UNIT_PORTB: fault_code = `RMS_LED_PORTB;
      rms_pkg::UNIT_PORTC: fault_code = `RMS_LED_PORTC;
      rms_pkg::UNIT_RAM: fault_code = `RMS_LED_RAM;
      rms_pkg::UNIT_ROM: fault_code = `RMS_LED_ROM;
      rms_pkg::UNIT_IRQ: fault_code = `RMS_LED_IRQ;
      rms_pkg::UNIT_KEYPRESS: fault_code = `RMS_LED_KEYPRESS;
      rms_pkg::UNIT_TIMER: fault_code = `RMS_LED_TIMER;
      rms_pkg::UNIT_PWM: fault_code = `RMS_LED_PWM;
      default: code_ok = 1'b0;
    endcase
  end

  // A failure freezes the pattern until the next reset
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !active_i)
    begin
      led_ff <= `RMS_LED_IDLE;
      failed_ff <= 1'b0;
    end
    else if (!failed_ff && fail_i && code_ok)
    begin
      led_ff <= fault_code;
      failed_ff <= 1'b1;
    end
    else if (!failed_ff && pass_i)
    begin
      led_ff <= ~led_ff;
    end
  end

  assign led_o = led_ff;
  assign failed_o = failed_ff;

endmodule : self_check_reporter

`default_nettype wire

// File: verif/rms_monitor.sv
// Bound checker for the reset/mode/watchdog block ports
`timescale 1ns/100ps
`default_nettype none

module rms_monitor #(
  parameter logic [15:0] USER_VECTOR = 16'h0000
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  // Pins
  input wire logic irq_hv_i,
  input wire logic mode_select_pin_i,
  // Core control, mode and report
  input wire logic cpu_clk_en_o,
  input wire logic osc_en_o,
  input wire logic wdog_reset_o,
  input wire logic self_check_mode_o,
  input wire logic [15:0] boot_vector_o,
  input wire logic selftest_restart_o,
  input wire logic report_led_3_o,
  input wire logic report_led_2_o,
  input wire logic report_led_1_o,
  input wire logic report_led_0_o
);
  logic off_ff;
  logic [3:0] led;
  logic strap;

  // Report pins and strap condition gathered for the properties
  assign led = {report_led_3_o, report_led_2_o, report_led_1_o, report_led_0_o};
  assign strap = irq_hv_i && mode_select_pin_i;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // Tracks a completed clear of the enable bit; any reset re-arms the dog
  always_ff @(posedge clk_i)
    if (rst_i || wdog_reset_o)
      off_ff <= 1'b0;
    else if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0]
             && wb_adr_i == 8'h74 && !wb_dat_i[6])
      off_ff <= 1'b1;

  // Multi-step behaviours
  sequence req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence ack_pulse_s;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  sequence dog_pulse_s;
    wdog_reset_o ##1 !wdog_reset_o;
  endsequence

  chk_ack_once: assert property (req_s |=> ack_pulse_s)
    else $error("bus ack not a single pulse one cycle after request");
  chk_wdog_pulse: assert property ($rose(wdog_reset_o) |=> dog_pulse_s)
    else $error("watchdog reset pulse not two cycles long");
  chk_wdog_reinit: assert property ($fell(wdog_reset_o) |-> cpu_clk_en_o && osc_en_o && led == 4'hF)
    else $error("watchdog reset did not return outputs to reset state");
  chk_wdog_only_on: assert property ($rose(wdog_reset_o) |-> !off_ff)
    else $error("watchdog reset while the watchdog was disabled");
  chk_stop_gated: assert property (!osc_en_o |-> off_ff && !cpu_clk_en_o)
    else $error("oscillator stopped while the watchdog was enabled");
  chk_recover_hold: assert property ($rose(osc_en_o) |-> !cpu_clk_en_o [*8])
    else $error("core clock resumed without stabilisation delay");
  chk_mode_latch: assert property ($fell(rst_i) |-> ##4 self_check_mode_o == $past(strap, 4))
    else $error("mode not taken from the strap at reset release");
  chk_boot_vector: assert property ($stable(self_check_mode_o)
    |-> boot_vector_o == (self_check_mode_o ? 16'h1600 : USER_VECTOR))
    else $error("boot vector does not match the mode");
  chk_user_leds: assert property (!self_check_mode_o && $stable(self_check_mode_o) |-> led == 4'hF)
    else $error("report leds active in user mode");
  chk_led_toggle: assert property (selftest_restart_o |=> led == ~$past(led))
    else $error("report leds did not toggle on a pass");
  chk_restart_mode: assert property (selftest_restart_o |-> self_check_mode_o)
    else $error("test restart outside self-check mode");
endmodule : rms_monitor

bind reset_mode_select_watchdog_stop rms_monitor #(.USER_VECTOR(USER_VECTOR)) mon (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
  .irq_hv_i(irq_hv_i), .mode_select_pin_i(mode_select_pin_i), .cpu_clk_en_o(cpu_clk_en_o),
  .osc_en_o(osc_en_o), .wdog_reset_o(wdog_reset_o), .self_check_mode_o(self_check_mode_o),
  .boot_vector_o(boot_vector_o), .selftest_restart_o(selftest_restart_o),
  .report_led_3_o(report_led_3_o), .report_led_2_o(report_led_2_o),
  .report_led_1_o(report_led_1_o), .report_led_0_o(report_led_0_o)
);
`default_nettype wire

// File: verif/mode_fixture.sv
// Board strapping and self-test fixture model for the mode pins
`timescale 1ns/100ps
`default_nettype none

module mode_fixture (
  // Clock and reset seen by the board
  input wire logic clk_i,
  input wire logic rst_i,
  // Requests from the bench
  input wire logic check_i,
  input wire logic wake_i,
  // Pins
  output logic irq_n_o,
  output logic irq_hv_o,
  output logic mode_pin_o
);
  logic [2:0] hold_ff;
  logic wiggle_ff;
  logic strap;

  // Counts cycles after reset release so the strap is held past the latch
  always_ff @(posedge clk_i)
    if (rst_i)
      hold_ff <= 3'h0;
    else if (hold_ff != 3'h7)
      hold_ff <= hold_ff + 3'h1;

  // Freed mode pin changes every cycle so a late sample would be caught
  always_ff @(posedge clk_i)
    if (rst_i)
      wiggle_ff <= 1'b0;
    else
      wiggle_ff <= ~wiggle_ff;

  // Strap held through reset and five cycles past release
  assign strap = rst_i || hold_ff < 3'h5;
  assign irq_hv_o = check_i && strap;
  assign mode_pin_o = strap ? check_i : wiggle_ff;
  // Interrupt line idles high, driven low only while wake is requested
  assign irq_n_o = ~wake_i;
endmodule : mode_fixture
`default_nettype wire

// File: verif/tb.sv
// Self-checking bench for the reset/mode/watchdog block
`timescale 1ns/100ps
`default_nettype none

module tb;
  localparam int unsigned TMO = 400;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic check = 1'b0;
  logic wake = 1'b0;
  wire logic irq_n;
  wire logic irq_hv;
  wire logic mpin;
  logic [31:0] rdat;
  logic ack, cke, osc, dog, scm, rsp;
  logic [15:0] vec;
  logic [3:0] led;
  logic [31:0] q;
  logic [3:0] prev;
  logic [3:0] codes [9] = '{4'hF, 4'hE, 4'hD, 4'hC, 4'hB, 4'hA, 4'h9, 4'h7, 4'h6};
  int err_total = 0;
  int checks = 0;
  int restarts = 0;

  // Free-running 20 MHz clock
  always #25 clk_i = ~clk_i;

  // Restart pulse lasts one cycle, so it is counted at every edge
  always @(posedge clk_i)
    if (rsp === 1'b1)
      restarts <= restarts + 1;

  mode_fixture fix (.clk_i(clk_i), .rst_i(rst_i), .check_i(check), .wake_i(wake),
    .irq_n_o(irq_n), .irq_hv_o(irq_hv), .mode_pin_o(mpin));

  reset_mode_select_watchdog_stop #(.WDOG_TIMEOUT_CYC(TMO)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .irq_n_i(irq_n), .irq_hv_i(irq_hv), .mode_select_pin_i(mpin), .cpu_clk_en_o(cke),
    .osc_en_o(osc), .wdog_reset_o(dog), .self_check_mode_o(scm), .boot_vector_o(vec),
    .selftest_restart_o(rsp), .report_led_3_o(led[3]), .report_led_2_o(led[2]),
    .report_led_1_o(led[1]), .report_led_0_o(led[0]));

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // One classic cycle; request held until ack is sampled, then a idle cycle
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h0, d};
    @(posedge clk_i);
    while (ack !== 1'b1)
      @(posedge clk_i);
    q = rdat;
    cyc <= 1'b0;
    @(posedge clk_i);
  endtask : bus

  task automatic await(ref logic s, input logic v, input int n);
    for (int i = 0; i < n && s !== v; i++)
      @(posedge clk_i);
    chk("await", {31'h0, s}, {31'h0, v});
  endtask : await

  // Two-cycle reset pulse with the strap set up while it is held
  task automatic restart(input logic sc);
    check <= sc;
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (6) @(posedge clk_i);
  endtask : restart

  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : conclude

  // Hang guard, well beyond the stop recovery and all resets
  initial
  begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    conclude();
  end

  initial
  begin
    restart(1'b0);
    bus(1'b0, 8'h74, 8'h00);
    chk("option", q, 32'h40);
    bus(1'b0, 8'h84, 8'h00);
    chk("status", q & 32'h7, 32'h6);
    chk("vector", {16'h0, vec}, 32'h0);
    bus(1'b0, 8'hFC, 8'h00);
    chk("unmapped", q, 32'h0);
    // Results written in user mode must leave the report alone
    bus(1'b1, 8'h88, 8'hC0);
    repeat (2) @(posedge clk_i);
    chk("user leds", {28'h0, led}, 32'hF);
    $display("test user reset done");
    // Stop with the dog running must degrade to wait
    bus(1'b1, 8'h80, 8'h06);
    repeat (3) @(posedge clk_i);
    chk("halt", {cke, osc}, 32'h1);
    bus(1'b0, 8'h84, 8'h00);
    chk("lp", q[7:4], 32'h2);
    wake <= 1'b1;
    await(cke, 1'b1, 10);
    wake <= 1'b0;
    repeat (4) @(posedge clk_i);
    $display("test stop as wait done");
    // Dog expires while waiting
    bus(1'b1, 8'h80, 8'h01);
    await(dog, 1'b1, TMO + 40);
    repeat (6) @(posedge clk_i);
    bus(1'b0, 8'h84, 8'h00);
    chk("dog rearmed", q & 32'h17, 32'h16);
    $display("test watchdog reset done");
    // Clear the enable, try to set it again, then a real stop
    bus(1'b1, 8'h74, 8'h00);
    bus(1'b1, 8'h74, 8'h40);
    bus(1'b0, 8'h74, 8'h00);
    chk("option off", q, 32'h0);
    bus(1'b1, 8'h80, 8'h02);
    repeat (TMO + 20) @(posedge clk_i);
    chk("stop", {cke, osc}, 32'h0);
    wake <= 1'b1;
    await(osc, 1'b1, 10);
    wake <= 1'b0;
    await(cke, 1'b1, 4200);
    $display("test stop done");
    // Self-check entry and flashing
    restart(1'b1);
    chk("mode", {31'h0, scm}, 32'h1);
    chk("entry", {16'h0, vec}, 32'h1600);
    repeat (2)
    begin
      prev = led;
      bus(1'b1, 8'h88, 8'h80);
      repeat (2) @(posedge clk_i);
      chk("flash", {28'h0, led}, {28'h0, ~prev});
    end
    chk("restarts", restarts, 32'h2);
    $display("test self-check pass done");
    // Every fault code, each frozen against a later pass
    for (int i = 0; i < 9; i++)
    begin
      restart(1'b1);
      bus(1'b1, 8'h88, 8'h40 | i[7:0]);
      bus(1'b1, 8'h88, 8'h80);
      repeat (2) @(posedge clk_i);
      chk("code", led, codes[i]);
    end
    chk("restarts", restarts, 32'h2);
    // An unknown unit is no fault code, so a later pass still flashes
    restart(1'b1);
    bus(1'b1, 8'h88, 8'h49);
    bus(1'b1, 8'h88, 8'h80);
    repeat (2) @(posedge clk_i);
    chk("unknown unit", {28'h0, led}, 32'h0);
    $display("test fault codes done");
    conclude();
  end
endmodule : tb
`default_nettype wire
